// ---- rtl/slot_io_regs.vh ----
// Constants for the integer and divisions slot exchange
`ifndef SLOT_IO_REGS_VH
`define SLOT_IO_REGS_VH
`define MAX_SLOTS 4
`define SEL_LSB 0
`define SEL_MSB 2
`define SEL_GROSS 3'h0
`define SEL_NET 3'h1
`define SEL_DISP 3'h2
`define SEL_TARE 3'h3
`define SEL_TARGET 3'h4
`define SEL_RATE 3'h5
`define CMD_LOAD_TARE 3
`define CMD_CLEAR_TARE 4
`define CMD_TARE 5
`define CMD_PRINT 6
`define CMD_ZERO 7
`define CMD_TARGET 8
`define CMD_MSG_LSB 9
`define CMD_MSG_MSB 11
`define CMD_OUT_LSB 12
`define CMD_OUT_MSB 14
`define CMD_LOAD_TARGET 15
`define ST_TARGET_LSB 0
`define ST_CMP_LSB 3
`define ST_ENTER 8
`define ST_IN_LSB 9
`define ST_MOTION 12
`define ST_NET 13
`define ST_UPDATING 14
`define ST_DATA_OK 15
`define MSG_PROMPT 3'h6
`define TARE_WAIT_MS 3000
`define CLK_KHZ 100000
`endif

// ---- rtl/slot_word_mem.v ----
// Small register-output memory holding the per-slot input words
`timescale 1ns/1ps
`default_nettype none
module slot_word_mem (
    input wire clk,
    input wire we,
    input wire [1:0] waddr,
    input wire [31:0] wdata,
    input wire [1:0] raddr,
    output reg [31:0] rdata
);
    reg [31:0] mem [0:3];
    always @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule
`default_nettype wire

// ---- rtl/scale_plc_integer_slot_io.v ----
// Integer and divisions format slot exchange between scale and controller
// Notes on behaviour
// - Each slot two words in, two out
// - First input word is selected signed weight
// - Select codes 0..5, above five gives gross
// - Status bits 0..2 show target logic
// - Status bits 3..7 show comparators five..one
// - Enter bit held until message field changes
// - Status bits 9..11 mirror hardware inputs
// - Status bit 12 shows motion
// - Status bit 13 shows net mode
// - Status bit 14 flags update in progress
// - Data ok bit; bad forces weight zero
// - Load tare rise copies value, net mode
// - Clear tare rise zeroes tare, gross mode
// - Tare rise takes weight once still, waits out motion up to three seconds
// - Print and zero requests on rising edges
// - Target start on rise, abort on fall
// - Message code from zero starts message event
// - Output bits drive free outputs by level
// - Load target rise copies value to target
// - Commands beyond select only in slot one
`timescale 1ns/1ps
`default_nettype none
`include "slot_io_regs.vh"
module scale_plc_integer_slot_io (
    input wire clk,
    input wire srst,
    input wire update_tick,
    input wire [2:0] slot_count_m1,
    input wire [127:0] out_words,
    input wire signed [15:0] gross_weight,
    input wire signed [15:0] displayed_weight,
    input wire signed [15:0] rate_value,
    input wire [2:0] target_state,
    input wire [4:0] comparator_state,
    input wire enter_key,
    input wire [2:0] hw_inputs,
    input wire motion,
    input wire data_ok,
    input wire [2:0] outputs_in_use,
    output reg [127:0] in_words,
    output reg signed [15:0] tare_q,
    output reg signed [15:0] target_q,
    output reg net_mode_q,
    output reg print_req_q,
    output reg zero_req_q,
    output reg target_start_q,
    output reg target_abort_q,
    output reg msg_event_q,
    output reg [2:0] message_code_var,
    output reg prompt_start_flag,
    output reg [2:0] discrete_out_q
);
    // Tare window of three seconds counted in clock cycles
    localparam [31:0] TARE_WAIT_CYC = `TARE_WAIT_MS * `CLK_KHZ;
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_FILL = 2'h1;
    localparam [1:0] ST_DONE = 2'h2;

    // Pin-side inputs pass two flops before use
    reg [31:0] sync1_q, sync2_q;
    wire enter_s = sync2_q[0];
    wire [2:0] hwin_s = sync2_q[3:1];
    wire motion_s = sync2_q[4];
    wire data_ok_s = sync2_q[5];
    wire [4:0] cmp_s = sync2_q[10:6];
    wire [2:0] tgt_s = sync2_q[13:11];
    wire [2:0] inuse_s = sync2_q[16:14];

    reg [15:0] cmd_prev_q;
    reg [1:0] state_q;
    reg [2:0] slot_q;
    reg [2:0] rd_slot_q;
    reg enter_q;
    reg [31:0] tare_wait_q;
    reg tare_pend_q;
    wire [31:0] mem_rdata;
    reg signed [15:0] gross_sync_q, gross_s1_q;
    reg signed [15:0] disp_sync_q, disp_s1_q;
    reg signed [15:0] rate_sync_q, rate_s1_q;
    integer i;

    // Command word of one slot
    function [15:0] slot_cmd;
        input [127:0] words;
        input [1:0] idx;
        begin
            slot_cmd = words[idx * 32 + 16 +: 16];
        end
    endfunction

    // Select codes above five report gross weight
    function signed [15:0] pick_weight;
        input [2:0] sel;
        input signed [15:0] gross;
        input signed [15:0] net;
        input signed [15:0] disp;
        input signed [15:0] tare;
        input signed [15:0] tgt;
        input signed [15:0] rate;
        begin
            case (sel)
                `SEL_NET: pick_weight = net;
                `SEL_DISP: pick_weight = disp;
                `SEL_TARE: pick_weight = tare;
                `SEL_TARGET: pick_weight = tgt;
                `SEL_RATE: pick_weight = rate;
                default: pick_weight = gross;
            endcase
        end
    endfunction

    // Only the first slot's command word drives actions; the rest only select
    wire [15:0] cmd0 = slot_cmd(out_words, 2'h0);
    wire [15:0] val0 = out_words[15:0];
    // Edges are taken against the command word held at the previous tick
    wire [15:0] rise = cmd0 & ~cmd_prev_q;
    wire [15:0] fall = ~cmd0 & cmd_prev_q;
    wire [2:0] msg_now = cmd0[`CMD_MSG_MSB:`CMD_MSG_LSB];
    wire [2:0] msg_prev = cmd_prev_q[`CMD_MSG_MSB:`CMD_MSG_LSB];
    wire signed [15:0] net_w = gross_sync_q - tare_q;

    // Status word as stored for each slot during the fill
    wire [15:0] status_w;
    assign status_w[`ST_TARGET_LSB +: 3] = tgt_s;
    assign status_w[`ST_CMP_LSB +: 5] = {cmp_s[0], cmp_s[1], cmp_s[2], cmp_s[3], cmp_s[4]};
    assign status_w[`ST_ENTER] = enter_q;
    assign status_w[`ST_IN_LSB +: 3] = hwin_s;
    assign status_w[`ST_MOTION] = motion_s;
    assign status_w[`ST_NET] = net_mode_q;
    assign status_w[`ST_UPDATING] = (state_q != ST_IDLE);
    assign status_w[`ST_DATA_OK] = data_ok_s;

    always @(posedge clk) begin
        sync1_q <= {15'h0000, inuse_pins(outputs_in_use), tgt_pins(target_state),
            comparator_state, data_ok, motion, hw_inputs, enter_key};
        sync2_q <= sync1_q;
        gross_s1_q <= gross_weight;
        gross_sync_q <= gross_s1_q;
        disp_s1_q <= displayed_weight;
        disp_sync_q <= disp_s1_q;
        rate_s1_q <= rate_value;
        rate_sync_q <= rate_s1_q;
    end

    function [2:0] inuse_pins;
        input [2:0] v;
        begin
            inuse_pins = v;
        end
    endfunction

    function [2:0] tgt_pins;
        input [2:0] v;
        begin
            tgt_pins = v;
        end
    endfunction

    // Command handling; edge actions once per update cycle, tare wait and enter latch every clock
    always @(posedge clk) begin
        if (srst) begin
            cmd_prev_q <= 16'h0000;
            tare_q <= 16'h0000;
            target_q <= 16'h0000;
            net_mode_q <= 1'b0;
            print_req_q <= 1'b0;
            zero_req_q <= 1'b0;
            target_start_q <= 1'b0;
            target_abort_q <= 1'b0;
            msg_event_q <= 1'b0;
            message_code_var <= 3'h0;
            prompt_start_flag <= 1'b0;
            discrete_out_q <= 3'h0;
            enter_q <= 1'b0;
            tare_pend_q <= 1'b0;
            tare_wait_q <= 32'h0000_0000;
        end else begin
            print_req_q <= 1'b0;
            zero_req_q <= 1'b0;
            target_start_q <= 1'b0;
            target_abort_q <= 1'b0;
            msg_event_q <= 1'b0;
            // Pending tare waits for stillness, gives up after the window
            if (tare_pend_q) begin
                if (!motion_s) begin
                    tare_q <= gross_sync_q;
                    net_mode_q <= 1'b1;
                    tare_pend_q <= 1'b0;
                end else if (tare_wait_q == 32'h0000_0000) begin
                    tare_pend_q <= 1'b0;
                end else begin
                    tare_wait_q <= tare_wait_q - 32'h0000_0001;
                end
            end
            // Edge actions fire only at the update tick
            if (update_tick) begin
                cmd_prev_q <= cmd0;
                if (rise[`CMD_LOAD_TARE]) begin
                    tare_q <= val0;
                    net_mode_q <= 1'b1;
                end
                if (rise[`CMD_CLEAR_TARE]) begin
                    tare_q <= 16'h0000;
                    net_mode_q <= 1'b0;
                end
                if (rise[`CMD_TARE]) begin
                    tare_pend_q <= 1'b1;
                    tare_wait_q <= TARE_WAIT_CYC[31:0];
                end
                print_req_q <= rise[`CMD_PRINT];
                zero_req_q <= rise[`CMD_ZERO];
                target_start_q <= rise[`CMD_TARGET];
                target_abort_q <= fall[`CMD_TARGET];
                if (rise[`CMD_LOAD_TARGET]) begin
                    target_q <= val0;
                end
                if (msg_prev == 3'h0 && msg_now != 3'h0) begin
                    msg_event_q <= 1'b1;
                    message_code_var <= msg_now;
                    if (msg_now == `MSG_PROMPT) begin
                        prompt_start_flag <= 1'b1;
                    end
                end
                // Free outputs follow command bits by level
                discrete_out_q <= (cmd0[`CMD_OUT_MSB:`CMD_OUT_LSB] & ~inuse_s) |
                    (discrete_out_q & inuse_s);
            end
            // Enter press wins over a clear in the same cycle
            if (enter_s) begin
                enter_q <= 1'b1;
            end else if (update_tick && msg_now != msg_prev) begin
                enter_q <= 1'b0;
            end
        end
    end

    // Refresh walk over the configured slots
    wire [1:0] last_slot = (slot_count_m1 > 3'h3) ? 2'h3 : slot_count_m1[1:0];
    // Read data lag the address by a cycle, so the drain runs one past the last slot
    wire [2:0] rd_end = {1'b0, last_slot} + 3'h1;
    wire [15:0] cmd_cur = slot_cmd(out_words, slot_q[1:0]);
    wire [2:0] sel_cur = cmd_cur[`SEL_MSB:`SEL_LSB];
    wire signed [15:0] wt_cur = data_ok_s ? pick_weight(sel_cur, gross_sync_q, net_w,
        disp_sync_q, tare_q, target_q, rate_sync_q) : 16'h0000;

    // Slot words are staged here, then copied out to the port in one pass
    slot_word_mem u_mem (
        .clk(clk),
        .we(state_q == ST_FILL),
        .waddr(slot_q[1:0]),
        .wdata({status_w, wt_cur}),
        .raddr(rd_slot_q[1:0]),
        .rdata(mem_rdata)
    );

    always @(posedge clk) begin
        if (srst) begin
            state_q <= ST_IDLE;
            slot_q <= 3'h0;
            rd_slot_q <= 3'h0;
            in_words <= 128'h0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (update_tick) begin
                        state_q <= ST_FILL;
                        slot_q <= 3'h0;
                    end
                end
                ST_FILL: begin
                    if (slot_q[1:0] == last_slot) begin
                        state_q <= ST_DONE;
                        rd_slot_q <= 3'h0;
                    end else begin
                        slot_q <= slot_q + 3'h1;
                    end
                end
                ST_DONE: begin
                    // Drain copies each slot out one cycle behind its read address
                    rd_slot_q <= rd_slot_q + 3'h1;
                    if (rd_slot_q != 3'h0) begin
                        in_words[(rd_slot_q - 3'h1) * 32 +: 32] <= mem_rdata;
                    end
                    if (rd_slot_q == rd_end) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
            // Update-in-progress flag is visible in every slot during the walk
            for (i = 0; i < `MAX_SLOTS; i = i + 1) begin
                in_words[i * 32 + 16 + `ST_UPDATING] <= (state_q != ST_IDLE) ||
                    update_tick;
            end
        end
    end
endmodule
`default_nettype wire

// ---- bench/slot_io_chk.sv ----
// Port checker for the slot exchange block
`timescale 1ns/1ps
`default_nettype none
module slot_io_chk (
    input wire logic clk,
    input wire logic srst,
    input wire logic update_tick,
    input wire logic [2:0] outputs_in_use,
    input wire logic [127:0] in_words,
    input wire logic signed [15:0] target_q,
    input wire logic signed [15:0] tare_q,
    input wire logic net_mode_q,
    input wire logic print_req_q,
    input wire logic target_start_q,
    input wire logic target_abort_q,
    input wire logic [2:0] message_code_var,
    input wire logic prompt_start_flag,
    input wire logic [2:0] discrete_out_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    pulse_one_a: assert property (print_req_q |=> !print_req_q)
        else $error("print pulse too long");
    print_tick_a: assert property (print_req_q |->
        $past(update_tick) || $past(update_tick, 2)) else $error("print without tick");
    busy_flag_a: assert property (update_tick |=> in_words[30])
        else $error("update flag not raised");
    target_tick_a: assert property (($changed(target_q) && !$past(srst)) |->
        $past(update_tick) || $past(update_tick, 2)) else $error("target load without tick");
    data_zero_a: assert property (!in_words[31] |-> in_words[15:0] == 16'h0000)
        else $error("weight not zero with data bad");
    start_abort_a: assert property (!(target_start_q && target_abort_q))
        else $error("start and abort together");
    prompt_code_a: assert property ($rose(prompt_start_flag) |-> message_code_var == 3'h6)
        else $error("prompt without code six");
    out_keep_a: assert property (($changed(discrete_out_q) && !$past(srst)) |->
        ((discrete_out_q ^ $past(discrete_out_q)) & outputs_in_use) == 3'h0)
        else $error("output in use overridden");
    clr_gross_a: assert property ($fell(net_mode_q) |-> tare_q == 16'sh0000)
        else $error("gross mode with tare left");
    cover property (print_req_q);
    cover property ($rose(net_mode_q));
    cover property ($rose(prompt_start_flag));
endmodule
`default_nettype wire

// ---- bench/plc_model.sv ----
// Controller model: output words and update ticks
`timescale 1ns/1ps
`default_nettype none
module plc_model (
    input wire logic clk,
    output logic update_tick,
    output logic [127:0] out_words
);
    initial begin
        update_tick = 1'b0;
        out_words = 128'h0;
    end
    // Value lands no later than its command bit, ahead of the sampling tick
    task put(input int k, input logic [15:0] v, input logic [15:0] c);
        @(posedge clk);
        out_words[32*k +: 32] <= {c, v};
    endtask
    task tick();
        @(posedge clk);
        update_tick <= 1'b1;
        @(posedge clk);
        update_tick <= 1'b0;
        repeat (12) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ---- bench/scale_plc_integer_slot_io_tb.sv ----
// Testbench for the slot exchange block
`timescale 1ns/1ps
`default_nettype none
module scale_plc_integer_slot_io_tb;
    logic clk, srst, enter_key, motion, data_ok, update_tick, net_mode_q, print_req_q;
    logic zero_req_q, target_start_q, target_abort_q, msg_event_q, prompt_start_flag;
    logic [2:0] slot_count_m1, target_state, hw_inputs, outputs_in_use;
    logic [2:0] message_code_var, discrete_out_q;
    logic [4:0] comparator_state, pv;
    logic signed [15:0] gross_weight, displayed_weight, rate_value, tare_q, target_q;
    logic signed [15:0] tare_e, tgt_e;
    logic [127:0] out_words, in_words;
    int err_total, checks, cyc;
    scale_plc_integer_slot_io u_dut (.clk, .srst, .update_tick, .slot_count_m1, .out_words,
        .gross_weight, .displayed_weight, .rate_value, .target_state, .comparator_state,
        .enter_key, .hw_inputs, .motion, .data_ok, .outputs_in_use, .in_words, .tare_q,
        .target_q, .net_mode_q, .print_req_q, .zero_req_q, .target_start_q, .target_abort_q,
        .msg_event_q, .message_code_var, .prompt_start_flag, .discrete_out_q);
    plc_model u_plc (.clk, .update_tick, .out_words);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        pv <= pv | {print_req_q, zero_req_q, target_start_q, target_abort_q, msg_event_q};
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            tally_and_finish();
        end
    end
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task tally_and_finish();
        if (err_total == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    function automatic logic [15:0] stat(input logic net, input logic ent);
        return {data_ok, 1'b0, net, motion, hw_inputs, ent, comparator_state[0],
            comparator_state[1], comparator_state[2], comparator_state[3],
            comparator_state[4], target_state};
    endfunction
    function automatic logic [15:0] wsel(input int s);
        case (s)
            1: return gross_weight - tare_e;
            2: return displayed_weight;
            3: return tare_e;
            4: return tgt_e;
            5: return rate_value;
            default: return gross_weight;
        endcase
    endfunction
    task cslot(input logic [15:0] w, input logic [15:0] s);
        chk("weight", in_words[15:0], w);
        chk("status", in_words[31:16], s);
    endtask
    task msg(input logic [15:0] c);
        @(negedge clk) pv = 5'h00;
        u_plc.put(0, 16'h0000, c);
        u_plc.tick();
    endtask
    initial begin
        srst = 1'b1;
        cyc = 0;
        pv = 5'h00;
        enter_key = 1'b0;
        motion = 1'b0;
        data_ok = 1'b1;
        slot_count_m1 = 3'h3;
        outputs_in_use = 3'h1;
        target_state = 3'h5;
        comparator_state = 5'h01;
        hw_inputs = 3'h3;
        gross_weight = 16'sh0123;
        displayed_weight = 16'sh0200;
        rate_value = 16'sh0300;
        tare_e = 16'sh0000;
        tgt_e = 16'sh0000;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        for (int r = 0; r < 2; r++) begin
            for (int k = 0; k < 4; k++) u_plc.put(k, 16'h0000, 16'(2 * k + r));
            u_plc.tick();
            for (int k = 0; k < 4; k++) begin
                chk("select", in_words[32*k +: 16], wsel(2 * k + r));
            end
        end
        u_plc.put(0, 16'h0020, 16'h0009);
        u_plc.put(1, 16'h0000, 16'h0010);
        u_plc.tick();
        tare_e = 16'sh0020;
        chk("tare", tare_q, tare_e);
        cslot(wsel(1), stat(1'b1, 1'b0));
        motion <= 1'b1;
        target_state <= 3'h2;
        comparator_state <= 5'h0c;
        hw_inputs <= 3'h4;
        u_plc.put(0, 16'h0000, 16'h0020);
        u_plc.tick();
        chk("tare moving", tare_q, tare_e);
        cslot(gross_weight, stat(1'b1, 1'b0));
        motion <= 1'b0;
        u_plc.tick();
        tare_e = gross_weight;
        chk("tare settled", tare_q, tare_e);
        u_plc.put(0, 16'h0000, 16'h0010);
        u_plc.tick();
        chk("tare cleared", tare_q, 16'h0000);
        chk("net mode", net_mode_q, 1'b0);
        u_plc.put(0, 16'h0055, 16'h8004);
        u_plc.tick();
        tgt_e = 16'sh0055;
        chk("target", target_q, tgt_e);
        chk("target sel", in_words[15:0], wsel(4));
        msg(16'h01c0);
        chk("pulses", pv, 5'b11100);
        msg(16'h0000);
        chk("abort", pv, 5'b00010);
        enter_key <= 1'b1;
        u_plc.tick();
        enter_key <= 1'b0;
        u_plc.tick();
        chk("enter", in_words[24], 1'b1);
        for (int n = 1; n < 8; n++) begin
            msg(16'h0000);
            msg(16'(n << 9));
            chk("message code", message_code_var, n[2:0]);
            chk("event", pv, 5'b00001);
        end
        chk("enter", in_words[24], 1'b0);
        chk("prompt", prompt_start_flag, 1'b1);
        msg(16'h0a00);
        chk("message held", message_code_var, 3'h7);
        u_plc.put(0, 16'h0000, 16'h7000);
        u_plc.tick();
        chk("outputs", discrete_out_q, 3'h6);
        data_ok <= 1'b0;
        slot_count_m1 <= 3'h0;
        u_plc.tick();
        cslot(16'h0000, stat(1'b0, 1'b0));
        chk("slot kept", in_words[47:32], gross_weight);
        tally_and_finish();
    end
endmodule
bind scale_plc_integer_slot_io slot_io_chk u_chk (.clk, .srst, .update_tick, .outputs_in_use,
    .in_words, .target_q, .tare_q, .net_mode_q, .print_req_q, .target_start_q, .target_abort_q,
    .message_code_var, .prompt_start_flag, .discrete_out_q);
`default_nettype wire
